// file: dv/ctlr_mem_model.sv
// main memory model: answers each fetch after lat cycles with one data pulse
// assumes mem_req stays high until the edge after the pulse
module ctlr_mem_model (
	input  wire logic        clk_sys,   // system clock
	input  wire logic        rst,       // async reset
	input  wire logic        mem_req,   // fetch request
	input  wire logic [31:0] mem_addr,  // line address
	input  wire logic [3:0]  lat,       // answer delay in cycles
	output logic             mem_valid, // line present
	output logic      [31:0] mem_data   // line data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	wire go = mem_req && !mem_valid && cnt_q == lat;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			mem_valid <= 1'b0;
			mem_data <= '0;
		end else begin
			mem_valid <= go;
			cnt_q <= (mem_req && !mem_valid && !go) ? cnt_q + 4'h1 : 4'h0;
			// data toggles outside the pulse so a late sample cannot pass
			mem_data <= go ? mem_addr ^ 32'h5A5A0F0F : ~mem_data;
		end
	end
endmodule

// file: dv/ctlr_tag_lookup_properties.sv
// port assertions for the tag lookup block
// assumes one clock domain and async active-high reset
module ctlr_tag_lookup_properties #(parameter int ENTRIES = 8192) (
	input wire logic                clk_sys,   // system clock
	input wire logic                rst,       // async reset, active high
	input wire logic                rd_req,    // read request
	input wire logic                rd_done,   // read answered
	input wire logic                hit,       // lookup hit
	input wire logic                cache_en,  // data cache enable
	input wire logic                mem_req,   // fetch request
	input wire logic                mem_valid, // fetched line present
	input wire ctlr_pkg::ctlr_org_t org,       // organisation
	input wire logic [31:0]         addr,      // processor address
	input wire logic [31:0]         rd_data,   // read data
	input wire logic [31:0]         mem_addr,  // fetch address
	input wire logic [31:0]         mem_data   // fetched line
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	hit_answer_a: assert property (hit |-> rd_done)
		else $error("hit without answer");
	hit_enable_a: assert property (rd_done |-> cache_en == hit)
		else $error("cache enable differs from hit");
	done_pulse_a: assert property (rd_done |=> !rd_done)
		else $error("answer longer than one cycle");
	line_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("fetch address not line aligned");
	fetch_line_a: assert property ($rose(mem_req) |-> mem_addr[31:2] == addr[31:2])
		else $error("fetch of wrong line");
	fetch_done_a: assert property (mem_req && mem_valid |=> !mem_req && rd_done
		&& rd_data == $past(mem_data))
		else $error("fetched line not returned");
	fetch_hold_a: assert property (mem_req && !mem_valid |=> mem_req)
		else $error("fetch dropped early");
	fetch_quiet_a: assert property (mem_req |-> !rd_done)
		else $error("answer during fetch");
	cover property (hit);
	cover property (mem_req && mem_valid);
	cover property (rd_done && !hit);
endmodule
bind ctlr_tag_lookup ctlr_tag_lookup_properties #(.ENTRIES(ENTRIES)) props_inst (
	.clk_sys(clk_sys), .rst(rst), .rd_req(rd_req), .rd_done(rd_done), .hit(hit),
	.cache_en(cache_en), .mem_req(mem_req), .mem_valid(mem_valid), .org(org),
	.addr(addr), .rd_data(rd_data), .mem_addr(mem_addr), .mem_data(mem_data));

// file: dv/ctlr_tag_lookup_test.sv
// testbench for the tag lookup block with the memory model
// rows: bit34 expected hit, bits33:32 organisation, bits31:0 address
module ctlr_tag_lookup_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst, rd_req, rd_done, hit, cache_en, mem_req, mem_valid;
	ctlr_pkg::ctlr_org_t org;
	logic [31:0] addr, rd_data, mem_addr, mem_data;
	logic [3:0] lat;
	int error_cnt, n_checks, cycles;
	localparam logic [35:0] ROWS [18] = '{36'h000001004, 36'h400001004, 36'h000009004,
		36'h000001004, 36'h000001008, 36'h400001004, 36'h000005004, 36'h400001004,
		36'h100001004, 36'h100005004, 36'h500001004, 36'h500005004, 36'h100009004,
		36'h500005004, 36'h100001004, 36'h200001004, 36'h600001004, 36'h200003004};
	ctlr_tag_lookup ctlr_tag_lookup_inst (.clk_sys(clk_sys), .rst(rst), .org(org),
		.rd_req(rd_req), .addr(addr), .rd_done(rd_done), .hit(hit), .rd_data(rd_data),
		.cache_en(cache_en), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_valid(mem_valid), .mem_data(mem_data));
	ctlr_mem_model ctlr_mem_model_inst (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req),
		.mem_addr(mem_addr), .lat(lat), .mem_valid(mem_valid), .mem_data(mem_data));
	always #25 clk_sys = ~clk_sys;
	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] o);
		@(posedge clk_sys);
		rst <= 1'b1;
		org <= ctlr_pkg::ctlr_org_t'(o);
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk("reset", {mem_req, rd_done, hit, cache_en}, 0);
	endtask
	task automatic access(input logic [31:0] a, input logic eh, input logic [3:0] l);
		@(posedge clk_sys);
		rd_req <= 1'b1;
		addr <= a;
		lat <= l;
		@(posedge clk_sys);
		rd_req <= 1'b0;
		for (int k = 0; k < 100 && rd_done !== 1'b1; k++) @(negedge clk_sys);
		chk("rd_done", 32'(rd_done), 1);
		chk("hit", 32'(hit), 32'(eh));
		chk("cache_en", 32'(cache_en), 32'(eh));
		chk("rd_data", rd_data, {a[31:2], 2'b00} ^ 32'h5A5A0F0F);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		{clk_sys, rst, rd_req, addr, lat, org} = {3'b010, 32'h0, 4'h0, ctlr_pkg::CTLR_DIRECT};
		for (int i = 0; i < 18; i++) begin
			if (i == 0 || ROWS[i][33:32] != ROWS[i-1][33:32]) do_reset(ROWS[i][33:32]);
			access(ROWS[i][31:0], ROWS[i][34], 4'(i % 3 * 3));
		end
		results();
	end
endmodule

// file: rtl/ctlr_pkg.sv
// constants shared by the cache tag lookup and replacement block
// assumes a 32-bit processor address and a 32 KByte cache of 4-byte lines
package ctlr_pkg;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int LINE_LSB   = 2;
	localparam int DM_IDX_W   = 13;
	localparam int W2_IDX_W   = 12;
	localparam int W4_IDX_W   = 11;
	localparam int DM_TAG_W   = 17;
	localparam int W2_TAG_W   = 18;
	localparam int W4_TAG_W   = 19;
	localparam int MAX_WAYS   = 4;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	typedef enum logic [1:0] {
		CTLR_DIRECT = 2'b00,
		CTLR_TWO    = 2'b01,
		CTLR_FOUR   = 2'b10
	} ctlr_org_t;
	typedef enum logic [1:0] {
		CTLR_IDLE  = 2'b00,
		CTLR_LOOK  = 2'b01,
		CTLR_FETCH = 2'b10
	} ctlr_state_t;
endpackage

// file: rtl/ctlr_tag_lookup.sv
// cache tag lookup, hit detection and way replacement for a 32 KByte cache
// assumes a processor that holds addr until done, and main memory that answers
// each fetch request with one mem_valid pulse carrying the line
// Notes on behaviour
// RQ1: index bits 2..14, 2..13 or 2..12
// RQ2: tag holds bits 15/14/13 up to 31
// RQ3: direct-mapped compares 17 MSBs at indexed entry
// RQ4: hit needs page match and valid bit
// RQ5: hit enables data cache read
// RQ6: data banks 1x8K, 2x4K or 4x2K words
// RQ7: direct-mapped miss refills the indexed location
// RQ8: two-way LRU bit updated every access
// RQ9: LRU set replaces way 1, else way 2
// RQ10: four-way victim from pseudorandom generator
// RQ11: one 4-byte word line per index
// RQ12: read miss fetches, writes data and tag
// RQ13: reset clears valid and LRU bits
module ctlr_tag_lookup #(
	parameter int ENTRIES = 8192
) (
	input  wire logic                           clk_sys,   // system clock
	input  wire logic                           rst,       // async reset, active high
	input  wire ctlr_pkg::ctlr_org_t            org,       // set organisation, static
	input  wire logic                           rd_req,    // processor read request
	input  wire logic [ctlr_pkg::ADDR_W-1:0]    addr,      // processor byte address
	output logic                                rd_done,   // read answered, one cycle
	output logic                                hit,       // lookup hit, one cycle
	output logic      [ctlr_pkg::DATA_W-1:0]    rd_data,   // read data
	output logic                                cache_en,  // data cache enabled for this read
	output logic                                mem_req,   // main memory fetch request
	output logic      [ctlr_pkg::ADDR_W-1:0]    mem_addr,  // fetch line address
	input  wire logic                           mem_valid, // fetched line present
	input  wire logic [ctlr_pkg::DATA_W-1:0]    mem_data   // fetched line
);
	localparam int AW = $clog2(ENTRIES);
	localparam int WAYS = ctlr_pkg::MAX_WAYS;

	// each bank holds ENTRIES/WAYS words; a four-way way is one bank, a two-way way two banks, the direct set all of them
	localparam int BANK = ENTRIES / WAYS;
	localparam int BW = $clog2(BANK);

	logic [ctlr_pkg::W4_TAG_W-1:0] tag_mem [WAYS][BANK];
	logic [ctlr_pkg::DATA_W-1:0]   dat_mem [WAYS][BANK];
	logic [BANK-1:0]               vld_q [WAYS];
	logic [BANK-1:0]               lru_q [2];

	ctlr_pkg::ctlr_state_t state_q, state_d;
	logic [15:0] lfsr_q;
	logic [ctlr_pkg::ADDR_W-1:0] addr_q;
	logic [1:0] vway_q;

	// address split per organisation
	wire [AW-1:0] line_idx = addr[ctlr_pkg::LINE_LSB +: AW]; // RQ11
	wire [AW-1:0] dm_idx   = line_idx; // RQ1
	wire [BW:0]   w2_idx   = addr[ctlr_pkg::LINE_LSB +: BW+1]; // RQ1
	wire [BW-1:0] w4_idx   = addr[ctlr_pkg::LINE_LSB +: BW]; // RQ1
	wire [ctlr_pkg::W4_TAG_W-1:0] page =
		(org == ctlr_pkg::CTLR_DIRECT) ? {2'b00, addr[ctlr_pkg::ADDR_W-1 -: ctlr_pkg::DM_TAG_W]} :
		(org == ctlr_pkg::CTLR_TWO) ? {1'b0, addr[ctlr_pkg::ADDR_W-1 -: ctlr_pkg::W2_TAG_W]} :
		addr[ctlr_pkg::ADDR_W-1 -: ctlr_pkg::W4_TAG_W]; // RQ2

	// physical bank and row for each logical way
	// direct: top two index bits pick the bank; two-way: ways 0,1 in banks {0,1}/{2,3}
	wire [BW-1:0] row = w4_idx;
	wire [1:0] dm_bank = dm_idx[AW-1 -: 2]; // RQ6
	wire       w2_half = w2_idx[BW]; // RQ6

	logic [WAYS-1:0] way_hit;
	logic [1:0] way_bank [WAYS];
	genvar g;
	generate
		for (g = 0; g < WAYS; g++) begin : g_way
			assign way_bank[g] =
				(org == ctlr_pkg::CTLR_DIRECT) ? dm_bank :
				(org == ctlr_pkg::CTLR_TWO) ? {1'(g % 2), w2_half} : 2'(g);
			wire active = (org == ctlr_pkg::CTLR_FOUR) || (org == ctlr_pkg::CTLR_TWO && g < 2)
				|| (org == ctlr_pkg::CTLR_DIRECT && g == 0);
			assign way_hit[g] = active && vld_q[way_bank[g]][row]
				&& (tag_mem[way_bank[g]][row] == page); // RQ3 RQ4
		end
	endgenerate

	wire any_hit = |way_hit;
	wire [1:0] hit_way = way_hit[3] ? 2'd3 : way_hit[2] ? 2'd2 : way_hit[1] ? 2'd1 : 2'd0;
	wire [BW-1:0] lru_row = row;
	wire lru_bit = lru_q[w2_half][lru_row];

	// lru set means way 0 (way 1 in the one-based naming) was used longer ago
	wire [1:0] victim =
		(org == ctlr_pkg::CTLR_DIRECT) ? 2'd0 : // RQ7
		(org == ctlr_pkg::CTLR_TWO) ? (lru_bit ? 2'd0 : 2'd1) : // RQ9
		lfsr_q[1:0]; // RQ10
	wire [1:0] vbank = way_bank[vway_q];
	wire refill = (state_q == ctlr_pkg::CTLR_FETCH) && mem_valid; // RQ12
	wire [1:0] used_way = (state_q == ctlr_pkg::CTLR_LOOK) ? hit_way : vway_q;
	wire access = (state_q == ctlr_pkg::CTLR_LOOK && any_hit) || refill;
	wire take_req = (state_q == ctlr_pkg::CTLR_IDLE) && rd_req;
	wire in_look  = (state_q == ctlr_pkg::CTLR_LOOK);
	wire look_hit = in_look && any_hit; // RQ5
	// free-running so the victim does not follow the request pattern
	wire [15:0] lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ ctlr_pkg::LFSR_TAPS) : (lfsr_q >> 1); // RQ10

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ctlr_pkg::CTLR_IDLE:  if (rd_req) state_d = ctlr_pkg::CTLR_LOOK;
			ctlr_pkg::CTLR_LOOK:  state_d = any_hit ? ctlr_pkg::CTLR_IDLE : ctlr_pkg::CTLR_FETCH;
			ctlr_pkg::CTLR_FETCH: if (mem_valid) state_d = ctlr_pkg::CTLR_IDLE;
			default:              state_d = ctlr_pkg::CTLR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ctlr_pkg::CTLR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lfsr_q <= ctlr_pkg::LFSR_SEED;
		end else begin
			lfsr_q <= lfsr_d; // RQ10
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			addr_q <= '0;
		end else if (take_req) begin
			addr_q <= addr;
		end
	end

	// victim is frozen at lookup so the refill cannot drift with the generator
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			vway_q <= 2'd0;
		end else if (in_look) begin
			vway_q <= victim; // RQ7 RQ9 RQ10
		end
	end

	// valid and lru bits: cleared at reset; valid set on refill, lru written on each two-way hit or refill
	generate
		for (g = 0; g < WAYS; g++) begin : g_vld
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					vld_q[g] <= '0; // RQ13
				else if (refill && vbank == 2'(g))
					vld_q[g][row] <= 1'b1; // RQ13
			end
		end
		for (g = 0; g < 2; g++) begin : g_lru
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst)
					lru_q[g] <= '0; // RQ13
				else if (access && org == ctlr_pkg::CTLR_TWO && w2_half == g[0])
					lru_q[g][lru_row] <= (used_way == 2'd1); // RQ8
			end
		end
	endgenerate

	// tag and data arrays have no reset; valid bits guard them
	always_ff @(posedge clk_sys) begin
		if (refill) begin
			tag_mem[vbank][row] <= page; // RQ12
			dat_mem[vbank][row] <= mem_data; // RQ12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_done <= 1'b0;
		end else begin
			rd_done <= access;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= look_hit; // RQ4
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cache_en <= 1'b0;
		end else begin
			cache_en <= look_hit; // RQ5
		end
	end

	// read data holds after the answer so a slow host can still take it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (look_hit) begin
			rd_data <= dat_mem[way_bank[hit_way]][row]; // RQ5
		end else if (refill) begin
			rd_data <= mem_data; // RQ12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_req <= 1'b0;
		end else begin
			mem_req <= (state_d == ctlr_pkg::CTLR_FETCH); // RQ12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_addr <= '0;
		end else begin
			mem_addr <= {addr_q[ctlr_pkg::ADDR_W-1:ctlr_pkg::LINE_LSB], 2'b00}; // RQ11
		end
	end
endmodule
